// ---- common/bmc_pkg.sv ----
// Shared constants and types for the minimum-mode bus control block.
package bmc_pkg;

    // Number of system clocks in one half of a processor clock state.
    localparam int unsigned BMC_HALF_DIV = 2;

    // Width of the cycle status code {io/mem select, direction, status low}.
    localparam int unsigned BMC_TYPE_W = 3;

    // Cycle status codes, ordered as {mem_io_select, xcvr_direction, cycle_status_low_n}.
    localparam logic [2:0] BMC_CYC_IRQ_ACK_STROBE_N    = 3'h0 | 3'h4;
    localparam logic [2:0] BMC_CYC_IO_RD   = 3'h5;
    localparam logic [2:0] BMC_CYC_IO_WR   = 3'h6;
    localparam logic [2:0] BMC_CYC_HALT    = 3'h7;
    localparam logic [2:0] BMC_CYC_CODE    = 3'h0;
    localparam logic [2:0] BMC_CYC_MEM_RD  = 3'h1;
    localparam logic [2:0] BMC_CYC_MEM_WR  = 3'h2;
    localparam logic [2:0] BMC_CYC_PASSIVE = 3'h3;

    // Bit positions inside a cycle status code.
    localparam int unsigned BMC_BIT_IOM = 2;
    localparam int unsigned BMC_BIT_DTR = 1;
    localparam int unsigned BMC_BIT_SS0 = 0;

    // Reset values of the status code and of floated lines (bus-hold keeps a one).
    localparam logic [2:0] BMC_TYPE_RST  = 3'h3;
    localparam logic       BMC_FLOAT_LVL = 1'b1;

    // Processor clock states, Gray coded along idle, T1, T2, T3, T4.
    typedef enum logic [2:0] {
        BMC_TI = 3'h0,
        BMC_T1 = 3'h1,
        BMC_T2 = 3'h3,
        BMC_T3 = 3'h2,
        BMC_T4 = 3'h6,
        BMC_TW = 3'h7,
        BMC_TH = 3'h4
    } bmc_state_t;

endpackage

// ---- hdl/bmc_phase_div.sv ----
// Divider that marks each half of a processor clock state with an enable pulse.
`timescale 1ns/1ps
module bmc_phase_div
    import bmc_pkg::*;
#(
    parameter int unsigned HALF_DIV = BMC_HALF_DIV
) (
    input  wire logic sys_clk_i,
    input  wire logic resetn_i,
    output logic      ph_en_o
);

    // Counter width covers the divide ratio even when it is one.
    localparam int unsigned CNT_W = (HALF_DIV > 1) ? $clog2(HALF_DIV) : 1;
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(HALF_DIV - 1);

    logic [CNT_W-1:0] cnt_q;    // System clocks elapsed in this half state.
    logic [CNT_W-1:0] cnt_d;    // Next counter value.
    logic             en_q;     // Registered enable pulse.
    logic             en_d;     // Next enable pulse.

    // The pulse is registered so that the consumer sees a clean one-cycle strobe.
    always_comb begin
        if (cnt_q == CNT_LAST) begin
            cnt_d = '0;
            en_d  = 1'b1;
        end else begin
            cnt_d = cnt_q + CNT_W'(1);
            en_d  = 1'b0;
        end
    end

    // Registers only.
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_q <= '0;
            en_q  <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            en_q  <= en_d;
        end
    end

    assign ph_en_o = en_q;

endmodule

// ---- hdl/bmc_bus_ctrl.sv ----
// Minimum-mode local bus control: strobes, transceiver control, hold handshake and status.
`timescale 1ns/1ps
module bmc_bus_ctrl
    import bmc_pkg::*;
#(
    parameter int unsigned HALF_DIV = BMC_HALF_DIV
) (
    input  wire logic                  sys_clk_i,
    input  wire logic                  resetn_i,
    input  wire logic                  cyc_req_i,
    input  wire logic [BMC_TYPE_W-1:0] cyc_type_i,
    input  wire logic                  wait_req_i,
    input  wire logic                  hold_req_i,
    output logic                       cyc_ack_o,
    output logic                       bus_hold_grant_o,
    output logic                       bus_float_o,
    output logic                       addr_latch_strobe_o,
    output logic                       irq_ack_strobe_n_o,
    output logic                       irq_ack_strobe_n_oe_n_o,
    output logic                       xcvr_output_enable_n_o,
    output logic                       xcvr_output_enable_n_oe_n_o,
    output logic                       xcvr_direction_o,
    output logic                       xcvr_direction_oe_n_o,
    output logic                       mem_io_select_o,
    output logic                       mem_io_select_oe_n_o,
    output logic                       cycle_status_low_n_o,
    output logic                       cycle_status_low_n_oe_n_o
);

    // Strobe values {latch, acknowledge_n, enable_n} for one half state.
    typedef logic [2:0] bmc_strb_t;

    logic                  ph_en;        // One pulse per half processor state.
    bmc_state_t            state_q;      // Current processor clock state.
    bmc_state_t            state_d;      // Next processor clock state.
    logic                  half_q;       // Second half of the state when set.
    logic                  half_d;       // Next half flag.
    logic [BMC_TYPE_W-1:0] type_q;       // Status code of the current or next cycle.
    logic [BMC_TYPE_W-1:0] type_d;       // Next status code.
    logic                  pend_q;       // A cycle was taken and starts at the next T1.
    logic                  pend_d;       // Next pending flag.
    logic                  grant_q;      // Hold grant.
    logic                  grant_d;      // Next hold grant.
    logic                  float_q;      // Bus and controls released.
    logic                  float_d;      // Next float flag.
    logic                  ack_q;        // One-cycle acceptance pulse.
    logic                  ack_d;        // Next acceptance pulse.
    bmc_strb_t             strb_q;       // Registered strobes.
    bmc_strb_t             strb_d;       // Next strobes.
    logic [BMC_TYPE_W-1:0] stat_q;       // Status pins as driven, bus-hold one when released.
    logic [BMC_TYPE_W-1:0] stat_d;       // Next status pins.

    // Half-state timing comes from the shared divider.
    bmc_phase_div #(
        .HALF_DIV (HALF_DIV)
    ) u_phase_div (
        .sys_clk_i (sys_clk_i),
        .resetn_i  (resetn_i),
        .ph_en_o   (ph_en)
    );

    // A write cycle drives data outward: direction bit set, but halt and passive are no transfer.
    function automatic logic is_write(input logic [BMC_TYPE_W-1:0] typ);
        return typ[BMC_BIT_DTR] && (typ != BMC_CYC_HALT) && (typ != BMC_CYC_PASSIVE);
    endfunction

    // Strobe levels at a given position of the bus cycle.
    function automatic bmc_strb_t strobes(input bmc_state_t            st,
                                          input logic                  hf,
                                          input logic [BMC_TYPE_W-1:0] typ);
        logic ale;
        logic ack_n;
        logic en_n;
        logic data;
        logic mid;
        ale   = (st == BMC_T1) && !hf;
        data  = (typ != BMC_CYC_HALT) && (typ != BMC_CYC_PASSIVE);
        mid   = (st == BMC_T3) || (st == BMC_TW) || ((st == BMC_T4) && !hf);
        ack_n = !((typ == BMC_CYC_IRQ_ACK_STROBE_N) &&
                  ((st == BMC_T2) || (st == BMC_T3) || (st == BMC_TW)));
        if (is_write(typ)) begin
            en_n = !(data && ((st == BMC_T2) || mid));
        end else begin
            en_n = !(data && (((st == BMC_T2) && hf) || mid));
        end
        return {ale, ack_n, en_n};
    endfunction

    // Sequencer: advances a half state on each enable and runs the hold handshake.
    always_comb begin
        state_d = state_q;
        half_d  = half_q;
        type_d  = type_q;
        pend_d  = pend_q;
        grant_d = grant_q;
        float_d = float_q;
        ack_d   = 1'b0;
        if (ph_en) begin
            if (!half_q) begin
                // Middle of a state: hold and new cycles are decided here.
                half_d = 1'b1;
                if ((state_q == BMC_T4) || (state_q == BMC_TI)) begin
                    if (hold_req_i && !pend_q) begin
                        // Hold wins over a waiting cycle; the cycle waits for release.
                        grant_d = 1'b1;
                        float_d = 1'b1;
                    end else if (cyc_req_i && !pend_q) begin
                        // Status for the next cycle turns valid in this T4 or idle state.
                        type_d = cyc_type_i;
                        pend_d = 1'b1;
                        ack_d  = 1'b1;
                    end
                end
            end else begin
                half_d = 1'b0;
                unique case (state_q)
                    BMC_TI, BMC_T4: begin
                        if (grant_q) begin
                            state_d = BMC_TH;
                        end else if (pend_q) begin
                            state_d = BMC_T1;
                            pend_d  = 1'b0;
                        end else begin
                            state_d = BMC_TI;
                        end
                    end
                    BMC_T1: begin
                        // A halt shows its status and latch pulse, then goes idle.
                        state_d = (type_q == BMC_CYC_HALT) ? BMC_TI : BMC_T2;
                    end
                    BMC_T2: begin
                        state_d = BMC_T3;
                    end
                    BMC_T3, BMC_TW: begin
                        state_d = wait_req_i ? BMC_TW : BMC_T4;
                    end
                    BMC_TH: begin
                        if (!hold_req_i) begin
                            grant_d = 1'b0;
                        end
                        // Lines stay released until a cycle actually needs the bus.
                        if (!grant_q && cyc_req_i) begin
                            float_d = 1'b0;
                            type_d  = cyc_type_i;
                            ack_d   = 1'b1;
                            state_d = BMC_T1;
                        end
                    end
                    default: begin
                        state_d = BMC_TI;
                    end
                endcase
            end
        end
        // Released lines show the bus-hold one; the latch strobe is driven low instead.
        // Folding the float into the flops keeps every pin free of output logic.
        if (float_d) begin
            strb_d = {1'b0, BMC_FLOAT_LVL, BMC_FLOAT_LVL};
            stat_d = {BMC_TYPE_W{BMC_FLOAT_LVL}};
        end else begin
            strb_d = strobes(state_d, half_d, type_d);
            stat_d = type_d;
        end
    end

    // Registers only.
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_q <= BMC_TI;
            half_q  <= 1'b0;
            type_q  <= BMC_TYPE_RST;
            pend_q  <= 1'b0;
            grant_q <= 1'b0;
            float_q <= 1'b0;
            ack_q   <= 1'b0;
            strb_q  <= 3'h3;
            stat_q  <= BMC_TYPE_RST;
        end else begin
            state_q <= state_d;
            half_q  <= half_d;
            type_q  <= type_d;
            pend_q  <= pend_d;
            grant_q <= grant_d;
            float_q <= float_d;
            ack_q   <= ack_d;
            strb_q  <= strb_d;
            stat_q  <= stat_d;
        end
    end

    // Every pin comes straight from a flop, so nothing glitches when the bus is released.
    assign cyc_ack_o                   = ack_q;
    assign bus_hold_grant_o            = grant_q;
    assign bus_float_o                 = float_q;
    assign addr_latch_strobe_o         = strb_q[2];
    assign irq_ack_strobe_n_o          = strb_q[1];
    assign irq_ack_strobe_n_oe_n_o     = float_q;
    assign xcvr_output_enable_n_o      = strb_q[0];
    assign xcvr_output_enable_n_oe_n_o = float_q;
    assign xcvr_direction_o            = stat_q[BMC_BIT_DTR];
    assign xcvr_direction_oe_n_o       = float_q;
    assign mem_io_select_o             = stat_q[BMC_BIT_IOM];
    assign mem_io_select_oe_n_o        = float_q;
    assign cycle_status_low_n_o        = stat_q[BMC_BIT_SS0];
    assign cycle_status_low_n_oe_n_o   = float_q;

endmodule

// ---- test/bmc_bus_ctrl_monitor.sv ----
// Checker that watches the bus control outputs at the block's ports.
`timescale 1ns/1ps
module bmc_bus_ctrl_monitor
    import bmc_pkg::*;
#(
    parameter int unsigned HALF_DIV = BMC_HALF_DIV
) (
    input wire logic       sys_clk_i,
    input wire logic       resetn_i,
    input wire logic [2:0] cyc_type_i,
    input wire logic       hold_req_i,
    input wire logic       cyc_ack_o,
    input wire logic       bus_hold_grant_o,
    input wire logic       bus_float_o,
    input wire logic       addr_latch_strobe_o,
    input wire logic       irq_ack_strobe_n_o,
    input wire logic       irq_ack_strobe_n_oe_n_o,
    input wire logic       xcvr_output_enable_n_o,
    input wire logic       xcvr_output_enable_n_oe_n_o,
    input wire logic       xcvr_direction_o,
    input wire logic       xcvr_direction_oe_n_o,
    input wire logic       mem_io_select_o,
    input wire logic       cycle_status_low_n_o,
    input wire logic       cycle_status_low_n_oe_n_o
);
    logic [2:0] code;      // Status code as the lines show it.
    logic [7:0] ale_run_q; // Clocks the latch strobe has been high so far.
    logic [7:0] ale_run_d; // Next value of that run length.
    assign code = {mem_io_select_o, xcvr_direction_o, cycle_status_low_n_o};
    // The run length restarts whenever the strobe is low.
    always_comb begin
        ale_run_d = addr_latch_strobe_o ? ale_run_q + 8'h01 : 8'h00;
    end
    // Register the run length.
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ale_run_q <= 8'h00;
        end else begin
            ale_run_q <= ale_run_d;
        end
    end
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);
    AST_IRQ_ACK_STROBE_N_STROBE:
        assert property (!irq_ack_strobe_n_o && !irq_ack_strobe_n_oe_n_o |-> code == BMC_CYC_IRQ_ACK_STROBE_N)
        else $error("acknowledge strobe low outside an acknowledge cycle");
    AST_ALE_WIDTH:
        assert property ($fell(addr_latch_strobe_o) |-> ale_run_q == 8'(HALF_DIV))
        else $error("latch strobe pulse has the wrong width");
    AST_ALE_HOLD:
        assert property (bus_float_o |-> !addr_latch_strobe_o)
        else $error("latch strobe high while the bus is released");
    AST_LINES_FLOAT:
        assert property (bus_float_o |-> xcvr_direction_oe_n_o && xcvr_output_enable_n_oe_n_o
            && cycle_status_low_n_oe_n_o && xcvr_direction_o && cycle_status_low_n_o)
        else $error("control line still driven while the bus is released");
    AST_RD_ENABLE:
        assert property ($fell(addr_latch_strobe_o) && !xcvr_direction_o
            |-> ##3 xcvr_output_enable_n_o ##1 !xcvr_output_enable_n_o)
        else $error("read enable does not start in mid T2");
    AST_WR_ENABLE:
        assert property ($fell(addr_latch_strobe_o) && xcvr_direction_o && !cycle_status_low_n_o
            |-> ##1 xcvr_output_enable_n_o ##1 !xcvr_output_enable_n_o)
        else $error("write enable does not start with T2");
    AST_GRANT_FLOAT:
        assert property (bus_hold_grant_o |-> bus_float_o)
        else $error("grant given without releasing the bus");
    AST_GRANT_RISE:
        assert property ($rose(bus_hold_grant_o) |-> $past(hold_req_i))
        else $error("grant raised without a hold request");
    AST_GRANT_DROP:
        assert property (bus_hold_grant_o && !hold_req_i |-> ##[1:16] !bus_hold_grant_o)
        else $error("grant kept after the request went away");
    AST_STATUS_LOAD:
        assert property (cyc_ack_o |-> code == $past(cyc_type_i))
        else $error("status lines do not carry the accepted cycle kind");
    AST_STATUS_HOLD:
        assert property (!$stable(code) && !bus_float_o && !$past(bus_float_o) |-> cyc_ack_o)
        else $error("status lines moved in mid cycle");
endmodule
bind bmc_bus_ctrl bmc_bus_ctrl_monitor #(.HALF_DIV(HALF_DIV)) u_mon (
    .sys_clk_i, .resetn_i, .cyc_type_i, .hold_req_i, .cyc_ack_o, .bus_hold_grant_o,
    .bus_float_o, .addr_latch_strobe_o, .irq_ack_strobe_n_o, .irq_ack_strobe_n_oe_n_o,
    .xcvr_output_enable_n_o, .xcvr_output_enable_n_oe_n_o, .xcvr_direction_o,
    .xcvr_direction_oe_n_o, .mem_io_select_o, .cycle_status_low_n_o,
    .cycle_status_low_n_oe_n_o);

// ---- test/bmc_far_side.sv ----
// Model of the other bus master and of the bus-hold cells on the shared lines.
`timescale 1ns/1ps
module bmc_far_side (
    input  wire logic sys_clk_i,
    input  wire logic hold_cmd_i,  // The other master wants the bus.
    input  wire logic dir_i,
    input  wire logic dir_oe_n_i,
    input  wire logic en_i,
    input  wire logic en_oe_n_i,
    input  wire logic ss_i,
    input  wire logic ss_oe_n_i,
    output logic      hold_req_o,  // Request, already in the processor clock domain.
    output logic      dir_w_o,
    output logic      en_w_o,
    output logic      ss_w_o
);
    // The request is launched from a flop so its setup time is always met.
    always_ff @(posedge sys_clk_i) begin
        hold_req_o <= hold_cmd_i;
    end
    // A released line is kept at one by its bus-hold cell.
    assign dir_w_o = dir_oe_n_i ? 1'b1 : dir_i;
    assign en_w_o  = en_oe_n_i ? 1'b1 : en_i;
    assign ss_w_o  = ss_oe_n_i ? 1'b1 : ss_i;
endmodule

// ---- test/min_mode_bus_control_tb.sv ----
// Self-checking testbench for the minimum-mode bus control block.
`timescale 1ns/1ps
module min_mode_bus_control_tb;
    import bmc_pkg::*;
    localparam int unsigned HD = BMC_HALF_DIV; // Half state length in system clocks.
    logic sys_clk_i, resetn_i, cyc_req_i, wait_req_i, hold_req_i, hold_cmd;
    logic [2:0] cyc_type_i;
    logic cyc_ack_o, bus_hold_grant_o, bus_float_o, addr_latch_strobe_o;
    logic irq_ack_strobe_n_o, irq_ack_strobe_n_oe_n_o, xcvr_output_enable_n_o;
    logic xcvr_output_enable_n_oe_n_o, xcvr_direction_o, xcvr_direction_oe_n_o;
    logic mem_io_select_o, mem_io_select_oe_n_o, cycle_status_low_n_o;
    logic cycle_status_low_n_oe_n_o, dir_w, en_w, ss_w;
    int fails, checked, n;
    logic [2:0] kinds [7] = '{BMC_CYC_IRQ_ACK_STROBE_N, BMC_CYC_IO_RD, BMC_CYC_IO_WR, BMC_CYC_CODE,
                              BMC_CYC_MEM_RD, BMC_CYC_MEM_WR, BMC_CYC_HALT};
    bmc_bus_ctrl #(.HALF_DIV(HD)) DUT (
        .sys_clk_i, .resetn_i, .cyc_req_i, .cyc_type_i, .wait_req_i, .hold_req_i,
        .cyc_ack_o, .bus_hold_grant_o, .bus_float_o, .addr_latch_strobe_o,
        .irq_ack_strobe_n_o, .irq_ack_strobe_n_oe_n_o, .xcvr_output_enable_n_o,
        .xcvr_output_enable_n_oe_n_o, .xcvr_direction_o, .xcvr_direction_oe_n_o,
        .mem_io_select_o, .mem_io_select_oe_n_o, .cycle_status_low_n_o,
        .cycle_status_low_n_oe_n_o);
    bmc_far_side u_far (
        .sys_clk_i, .hold_cmd_i(hold_cmd), .dir_i(xcvr_direction_o),
        .dir_oe_n_i(xcvr_direction_oe_n_o), .en_i(xcvr_output_enable_n_o),
        .en_oe_n_i(xcvr_output_enable_n_oe_n_o), .ss_i(cycle_status_low_n_o),
        .ss_oe_n_i(cycle_status_low_n_oe_n_o), .hold_req_o(hold_req_i),
        .dir_w_o(dir_w), .en_w_o(en_w), .ss_w_o(ss_w));
    initial begin
        sys_clk_i = 1'b0;
        forever #20 sys_clk_i = ~sys_clk_i;
    end
    // Compare one value and count the outcome.
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    // Clocks of low enable: reads from mid T2, writes from T2, to mid T4, plus waits.
    function automatic logic [7:0] exp_en(logic [2:0] t, logic w);
        // Halt and passive cycles move no data, so the transceiver stays shut.
        if (t == BMC_CYC_HALT || t == BMC_CYC_PASSIVE) return 8'h00;
        return 8'(((t[1] && !t[0]) ? 5 : 4) * HD + 2 * HD * w);
    endfunction
    // Run one bus cycle and count the strobes it produces.
    task automatic run_cycle(input logic [2:0] t, input logic w_in);
        int k, ale_n, en_n, st_n;
        logic w;
        w = w_in && (t != BMC_CYC_HALT);
        k = 0;
        ale_n = 0;
        en_n = 0;
        st_n = 0;
        cyc_req_i = 1'b1;
        cyc_type_i = t;
        wait_req_i = w;
        do begin
            @(posedge sys_clk_i);
            #1;
            k++;
        end while (cyc_ack_o !== 1'b1 && k < 200);
        cyc_req_i = 1'b0;
        chk("ack", {7'h00, cyc_ack_o}, 8'h01);
        chk("status", {5'h00, mem_io_select_o, xcvr_direction_o, cycle_status_low_n_o},
            {5'h00, t});
        chk("float", {7'h00, bus_float_o}, 8'h00);
        // After a hold the cycle starts at T1 with the acknowledge, so count that clock too.
        ale_n = int'(addr_latch_strobe_o);
        repeat (40) begin
            @(posedge sys_clk_i);
            #1;
            ale_n += int'(addr_latch_strobe_o);
            en_n += int'(!xcvr_output_enable_n_o);
            st_n += int'(!irq_ack_strobe_n_o && !irq_ack_strobe_n_oe_n_o);
            // Releasing the wait request in mid wait state gives exactly one wait.
            if (en_n == int'(exp_en(t, 1'b0))) wait_req_i = 1'b0;
        end
        chk("latch pulse", 8'(ale_n), 8'(HD));
        chk("enable", 8'(en_n), exp_en(t, w));
        chk("ack strobe", 8'(st_n),
            (t == BMC_CYC_IRQ_ACK_STROBE_N) ? 8'(4 * HD + 2 * HD * w) : 8'h00);
    endtask
    // Print the counts and the verdict, then stop.
    task automatic tally_and_finish();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        #800000;
        fails++;
        tally_and_finish();
    end
    initial begin
        fails = 0;
        checked = 0;
        resetn_i = 1'b0;
        cyc_req_i = 1'b0;
        wait_req_i = 1'b0;
        hold_cmd = 1'b0;
        cyc_type_i = BMC_CYC_PASSIVE;
        void'($urandom(67));
        repeat (10) @(posedge sys_clk_i);
        #1 resetn_i = 1'b1;
        chk("reset", {4'h0, bus_hold_grant_o, mem_io_select_o, xcvr_direction_o,
            cycle_status_low_n_o}, {5'h00, BMC_TYPE_RST});
        $display("test reset done");
        // Every cycle kind but passive, first without and then with a wait state (halt never waits).
        for (int i = 0; i < 14; i++) run_cycle(kinds[i % 7], i >= 7);
        for (int i = 0; i < 10; i++) run_cycle(kinds[$urandom_range(0, 6)], 1'($urandom()));
        // A passive cycle still pulses the latch but must leave the transceiver shut.
        run_cycle(BMC_CYC_PASSIVE, 1'b0);
        $display("test cycles done");
        // Another master takes the bus; a request meanwhile must wait.
        hold_cmd = 1'b1;
        n = 0;
        while (bus_hold_grant_o !== 1'b1 && n < 40) begin
            @(posedge sys_clk_i);
            #1;
            n++;
        end
        chk("grant", {7'h00, bus_hold_grant_o}, 8'h01);
        chk("released", {1'b0, mem_io_select_o, mem_io_select_oe_n_o, irq_ack_strobe_n_oe_n_o,
            addr_latch_strobe_o, dir_w, en_w, ss_w}, 8'h77);
        cyc_req_i = 1'b1;
        cyc_type_i = BMC_CYC_MEM_RD;
        n = 0;
        repeat (20) begin
            @(posedge sys_clk_i);
            #1;
            n += int'(cyc_ack_o !== 1'b0);
        end
        chk("ack in hold", 8'(n), 8'h00);
        hold_cmd = 1'b0;
        n = 0;
        while (bus_hold_grant_o !== 1'b0 && n < 40) begin
            @(posedge sys_clk_i);
            #1;
            n++;
        end
        chk("grant drop", {7'h00, bus_hold_grant_o}, 8'h00);
        run_cycle(BMC_CYC_MEM_RD, 1'b0);
        $display("test hold done");
        tally_and_finish();
    end
endmodule
